// file: common/tfp_defs.svh
// Register offsets, field positions, mode codes, TOP values and prescale factors of the timer
`ifndef TFP_DEFS_SVH
`define TFP_DEFS_SVH
`define TFP_ADDR_W 8
`define TFP_OFS_CTRL_A 8'h00
`define TFP_OFS_CTRL_B 8'h04
`define TFP_OFS_CTRL_C 8'h08
`define TFP_OFS_COUNT 8'h0c
`define TFP_OFS_CMP_A 8'h10
`define TFP_OFS_CMP_B 8'h14
`define TFP_OFS_CAPTURE 8'h18
`define TFP_OFS_PORT 8'h1c
`define TFP_OFS_STATUS 8'h20
`define TFP_FLD_FORCE_A 7
`define TFP_FLD_FORCE_B 6
`define TFP_FLD_OVF 0
`define TFP_WGM_NORMAL 4'h0
`define TFP_WGM_CTC_CMP 4'h4
`define TFP_WGM_FAST8 4'h5
`define TFP_WGM_FAST9 4'h6
`define TFP_WGM_FAST10 4'h7
`define TFP_WGM_CTC_CAP 4'hc
`define TFP_WGM_FAST_CAP 4'he
`define TFP_WGM_FAST_CMP 4'hf
`define TFP_TOP_8 16'h00ff
`define TFP_TOP_9 16'h01ff
`define TFP_TOP_10 16'h03ff
`define TFP_TOP_MAX 16'hffff
`define TFP_DIV_1 11'h001
`define TFP_DIV_8 11'h008
`define TFP_DIV_64 11'h040
`define TFP_DIV_256 11'h100
`define TFP_DIV_1024 11'h400
`define TFP_RESP_OKAY 2'h0
`define TFP_RESP_SLVERR 2'h2
`endif

// file: common/tfp_pkg.sv
// Types shared by the timer compare-output block
package tfp_pkg;
   typedef enum logic [1:0] {TFP_WAVE_NORMAL, TFP_WAVE_CTC, TFP_WAVE_FAST} tfp_wave_type;
   typedef struct packed {
      logic [1:0] com_a;
      logic [1:0] com_b;
      logic [3:0] wgm;
      logic [2:0] clk_sel;
   } tfp_ctrl_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } tfp_wreq_type;
   typedef struct packed {
      logic [1:0] level;
      logic [1:0] enable;
   } tfp_pins_type;
endpackage : tfp_pkg

// file: rtl/tfp_timer.sv
// 16-bit timer with two compare outputs, fast PWM and an AXI4-Lite register slave
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tfp_defs.svh"
module tfp_timer (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Compare output pins
   output tfp_pkg::tfp_pins_type pins
);
   import tfp_pkg::*;

   function automatic tfp_wave_type wave_kind(input logic [3:0] wgm);
      case (wgm)
         `TFP_WGM_CTC_CMP, `TFP_WGM_CTC_CAP: wave_kind = TFP_WAVE_CTC;
         `TFP_WGM_FAST8, `TFP_WGM_FAST9, `TFP_WGM_FAST10,
         `TFP_WGM_FAST_CAP, `TFP_WGM_FAST_CMP: wave_kind = TFP_WAVE_FAST;
         default: wave_kind = TFP_WAVE_NORMAL;
      endcase
   endfunction : wave_kind

   function automatic logic [15:0] top_of(input logic [3:0] wgm, input logic [15:0] cmp_a,
                                          input logic [15:0] cap);
      case (wgm)
         `TFP_WGM_FAST8: top_of = `TFP_TOP_8;
         `TFP_WGM_FAST9: top_of = `TFP_TOP_9;
         `TFP_WGM_FAST10: top_of = `TFP_TOP_10;
         `TFP_WGM_CTC_CMP, `TFP_WGM_FAST_CMP: top_of = cmp_a;
         `TFP_WGM_CTC_CAP, `TFP_WGM_FAST_CAP: top_of = cap;
         default: top_of = `TFP_TOP_MAX;
      endcase
   endfunction : top_of

   function automatic logic [10:0] divisor(input logic [2:0] sel);
      case (sel)
         3'h1: divisor = `TFP_DIV_1;
         3'h2: divisor = `TFP_DIV_8;
         3'h3: divisor = `TFP_DIV_64;
         3'h4: divisor = `TFP_DIV_256;
         default: divisor = `TFP_DIV_1024;
      endcase
   endfunction : divisor

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction : merge16

   // Non-PWM match action, shared by real matches and force strobes
   function automatic logic match_action(input logic [1:0] com, input logic cur);
      case (com)
         2'h1: match_action = ~cur;
         2'h2: match_action = 1'b0;
         2'h3: match_action = 1'b1;
         default: match_action = cur;
      endcase
   endfunction : match_action

   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr[1:0] == 2'h0) && (addr <= `TFP_OFS_STATUS);
   endfunction : mapped

   tfp_ctrl_type ctrl;
   tfp_wreq_type wreq;
   logic [1:0] dir;
   logic [1:0] port_data;
   logic [1:0] oc;
   logic [15:0] cnt;
   logic [15:0] icr;
   logic [1:0][15:0] cmp_buf;
   logic [1:0][15:0] cmp_act;
   logic ovf_flag;
   logic [1:0] match_flag;
   logic block;
   logic [9:0] pre_cnt;
   logic tick;

   tfp_wave_type wave;
   logic [15:0] top;
   logic at_top;
   logic wrap;
   logic [1:0] match;
   logic wr_en;
   logic [10:0] div_m1;
   logic [31:0] next_rdata;
   logic [1:0][1:0] com_sel;

   assign wave = wave_kind(ctrl.wgm);
   assign top = top_of(ctrl.wgm, cmp_act[0], icr);
   assign at_top = (cnt == top);
   assign wrap = tick && at_top;
   assign match[0] = tick && !block && (cnt == cmp_act[0]);
   assign match[1] = tick && !block && (cnt == cmp_act[1]);
   assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign div_m1 = divisor(ctrl.clk_sel) - 11'h001;
   assign com_sel = {ctrl.com_b, ctrl.com_a};

   // Write channel: address and data taken in either order, one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TFP_RESP_OKAY;
         wreq <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wreq.addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wreq.data <= s_axi_wdata;
            wreq.strb <= s_axi_wstrb;
         end
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wreq.addr) ? `TFP_RESP_OKAY : `TFP_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
         `TFP_OFS_CTRL_A: next_rdata[7:0] = {ctrl.com_a, ctrl.com_b, 2'h0, ctrl.wgm[1:0]};
         `TFP_OFS_CTRL_B: next_rdata[7:0] = {3'h0, ctrl.wgm[3:2], ctrl.clk_sel};
         `TFP_OFS_COUNT: next_rdata[15:0] = cnt;
         `TFP_OFS_CMP_A: next_rdata[15:0] = cmp_buf[0];
         `TFP_OFS_CMP_B: next_rdata[15:0] = cmp_buf[1];
         `TFP_OFS_CAPTURE: next_rdata[15:0] = icr;
         `TFP_OFS_PORT: next_rdata[7:0] = {2'h0, oc, port_data, dir};
         `TFP_OFS_STATUS: next_rdata[7:0] = {5'h00, match_flag, ovf_flag};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TFP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= mapped(s_axi_araddr) ? `TFP_RESP_OKAY : `TFP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Control fields; compare mode is read live, so a change acts at the next match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= '0;
         dir <= 2'h0;
         port_data <= 2'h0;
         icr <= 16'h0000;
      end else if (wr_en) begin
         if (wreq.addr == `TFP_OFS_CTRL_A && wreq.strb[0]) begin
            ctrl.com_a <= wreq.data[7:6];
            ctrl.com_b <= wreq.data[5:4];
            ctrl.wgm[1:0] <= wreq.data[1:0];
         end
         if (wreq.addr == `TFP_OFS_CTRL_B && wreq.strb[0]) begin
            ctrl.wgm[3:2] <= wreq.data[4:3];
            ctrl.clk_sel <= wreq.data[2:0];
         end
         if (wreq.addr == `TFP_OFS_PORT && wreq.strb[0]) begin
            dir <= wreq.data[1:0];
            port_data <= wreq.data[3:2];
         end
         // Only software loads the capture register; compare mode has no path here
         if (wreq.addr == `TFP_OFS_CAPTURE) begin
            icr <= merge16(icr, wreq.data, wreq.strb);
         end
      end
   end

   // Prescaler: enable every N clocks; >= so a smaller new divisor never stalls the count
   always_ff @(posedge aclk) begin
      if (!aresetn || ctrl.clk_sel == 3'h0 || ctrl.clk_sel > 3'h5) begin
         pre_cnt <= 10'h000;
         tick <= 1'b0;
      end else if (pre_cnt >= div_m1[9:0]) begin
         pre_cnt <= 10'h000;
         tick <= 1'b1;
      end else begin
         pre_cnt <= pre_cnt + 10'h001;
         tick <= 1'b0;
      end
   end

   // Counter; a software write wins over a tick and masks the following tick's match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 16'h0000;
         block <= 1'b0;
      end else if (wr_en && wreq.addr == `TFP_OFS_COUNT) begin
         cnt <= merge16(cnt, wreq.data, wreq.strb);
         block <= 1'b1;
      end else if (tick) begin
         block <= 1'b0;
         cnt <= at_top ? 16'h0000 : cnt + 16'h0001;
      end
   end

   // Compare values: straight through outside fast PWM, buffered inside it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_buf <= '0;
         cmp_act <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_en && wreq.addr == (i == 0 ? `TFP_OFS_CMP_A : `TFP_OFS_CMP_B)) begin
               cmp_buf[i] <= merge16(cmp_buf[i], wreq.data, wreq.strb);
               if (wave != TFP_WAVE_FAST) begin
                  cmp_act[i] <= merge16(cmp_buf[i], wreq.data, wreq.strb);
               end
            end
            // Load at the wrap so a period never sees a half-updated value
            if (wave == TFP_WAVE_FAST && wrap) begin
               cmp_act[i] <= cmp_buf[i];
            end
         end
      end
   end

   // Sticky flags, write one to clear; a set in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_flag <= 1'b0;
         match_flag <= 2'h0;
      end else begin
         if (wr_en && wreq.addr == `TFP_OFS_STATUS && wreq.strb[0]) begin
            ovf_flag <= ovf_flag & ~wreq.data[`TFP_FLD_OVF];
            match_flag <= match_flag & ~wreq.data[2:1];
         end
         if (wrap) begin
            ovf_flag <= 1'b1;
         end
         if (match[0]) begin
            match_flag[0] <= 1'b1;
         end
         if (match[1]) begin
            match_flag[1] <= 1'b1;
         end
      end
   end

   // Compare output state: preset first, then force, then timer events
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         oc <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_en && wreq.addr == `TFP_OFS_PORT && wreq.strb[0]) begin
               oc[i] <= wreq.data[4 + i];
            end else if (wr_en && wreq.addr == `TFP_OFS_CTRL_C && wave != TFP_WAVE_FAST
                         && wreq.data[`TFP_FLD_FORCE_A - i]) begin
               oc[i] <= match_action(com_sel[i], oc[i]);
            end else if (wave == TFP_WAVE_FAST) begin
               if (com_sel[i] == 2'h1) begin
                  if (i == 0 && ctrl.wgm == `TFP_WGM_FAST_CMP && match[0]) begin
                     oc[0] <= ~oc[0];
                  end
               end else if (com_sel[i][1]) begin
                  // Compare at TOP keeps the match level, giving a constant output
                  if (wrap && cmp_act[i] != top) begin
                     oc[i] <= (com_sel[i] != 2'h2);
                  end else if (match[i]) begin
                     oc[i] <= (com_sel[i] == 2'h2);
                  end
               end
            end else if (match[i]) begin
               oc[i] <= match_action(com_sel[i], oc[i]);
            end
         end
      end
   end

   // Pin drive: waveform replaces the port value, direction stays with software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins <= '0;
      end else begin
         pins.level[0] <= (ctrl.com_a != 2'h0) ? oc[0] : port_data[0];
         pins.level[1] <= (ctrl.com_b != 2'h0) ? oc[1] : port_data[1];
         pins.enable <= dir;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_PIN_OVERRIDE: assert property ((ctrl.com_a != 2'h0) |=> pins.level[0] == $past(oc[0]))
      else $error("Pin A does not show compare output");
   AST_PIN_DIRECTION: assert property (1'b1 |=> pins.enable == $past(dir))
      else $error("Pin enable does not follow direction bits");
   AST_PRESET: assert property ((wr_en && wreq.addr == `TFP_OFS_PORT && wreq.strb[0])
      |=> oc == $past(wreq.data[5:4]))
      else $error("Compare output preset lost");
   AST_CAPTURE_STABLE: assert property (!(wr_en && wreq.addr == `TFP_OFS_CAPTURE)
      |=> $stable(icr))
      else $error("Capture register changed without a write");
   AST_COM_ZERO: assert property ((match[0] && ctrl.com_a == 2'h0 && !wr_en)
      |=> $stable(oc[0]))
      else $error("Mode zero changed output A");
   AST_FORCE_CLEAR: assert property ((wr_en && wreq.addr == `TFP_OFS_CTRL_C
      && wreq.data[`TFP_FLD_FORCE_A] && wave != TFP_WAVE_FAST && ctrl.com_a == 2'h2)
      |=> !oc[0])
      else $error("Force strobe did not clear output A");
   AST_COUNT_STEP: assert property ((tick && !at_top && !wr_en) |=> cnt == $past(cnt) + 16'h0001)
      else $error("Counter did not step");
   AST_NONPWM_TOGGLE: assert property ((match[0] && wave != TFP_WAVE_FAST && ctrl.com_a == 2'h1
      && !wr_en) |=> oc[0] != $past(oc[0]))
      else $error("Output A did not toggle");
   AST_FAST_MATCH: assert property ((wave == TFP_WAVE_FAST && match[0] && !wrap && !wr_en
      && ctrl.com_a == 2'h3) |=> !oc[0])
      else $error("Non-inverted output not cleared at match");
   AST_FAST_WRAP: assert property ((wave == TFP_WAVE_FAST && wrap && ctrl.com_a == 2'h2
      && cmp_act[0] != top && !wr_en) |=> !oc[0])
      else $error("Inverted output not cleared at wrap");
   AST_TICK_GAP: assert property ((tick && ctrl.clk_sel == 3'h2 && !wr_en)
      |=> (!tick)[*7])
      else $error("Divide by eight tick spacing wrong");
   AST_BLOCK: assert property ((wr_en && wreq.addr == `TFP_OFS_COUNT) |=> match == 2'h0)
      else $error("Match not suppressed after counter write");
   AST_HOLD_ACTIVE: assert property ((wave == TFP_WAVE_FAST && !wrap)
      |=> $stable(cmp_act))
      else $error("Active compare value changed mid period");
   AST_WRAP_COUNT: assert property ((wave == TFP_WAVE_FAST && wrap && !wr_en)
      |=> cnt == 16'h0000 && ovf_flag)
      else $error("Fast PWM wrap or overflow flag wrong");

   COV_FAST_WRAP: cover property (wave == TFP_WAVE_FAST && wrap && ctrl.com_a == 2'h3);
   COV_FORCE: cover property (wr_en && wreq.addr == `TFP_OFS_CTRL_C);
   COV_BLOCKED: cover property (tick && block && cnt == cmp_act[0]);
   COV_HALF_CLOCK: cover property (ctrl.wgm == `TFP_WGM_FAST_CMP && match[0] ##1 match[0]);
endmodule : tfp_timer

// file: testbench/test_timer_fast_pwm_compare_output.sv
// Self-checking bench for the timer compare-output block driven over its register bus
`timescale 1ns/1ps
`include "tfp_defs.svh"
module test_timer_fast_pwm_compare_output;
   import tfp_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   tfp_pins_type pins;
   int n_fail = 0;
   int total_checks = 0;
   int hi;
   int ch;
   logic [1:0] resp;
   logic [31:0] rdv;
   // Force table: compare mode, preset state, expected state
   logic [1:0] f_com [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
   logic f_pre [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   logic f_exp [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   // Fast 8-bit PWM table: compare mode, compare value, high clocks per period
   logic [1:0] p_com [6] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
   logic [31:0] p_cmp [6] = '{32'h40, 32'h40, 32'h0, 32'h0, 32'hff, 32'hff};
   logic [31:0] p_hi [6] = '{32'h41, 32'hbf, 32'h1, 32'hff, 32'h0, 32'h100};

   tfp_timer dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins
   );

   initial begin
      forever #2 aclk = ~aclk;
   end

   task stop_test;
      if (n_fail == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Address and data are offered together; bready may stand high early
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rdv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // High clocks and level changes of pin k over n clocks; phase does not matter
   task measure(input int n, input int k);
      logic last;
      hi = 0;
      ch = 0;
      @(posedge aclk);
      last = pins.level[k];
      repeat (n) begin
         @(posedge aclk);
         if (pins.level[k] === 1'b1) hi++;
         if (pins.level[k] !== last) ch++;
         last = pins.level[k];
      end
   endtask : measure

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`TFP_OFS_CTRL_A);
      check("ctrl_a reset", rdv, 32'h0);
      rd(8'h24);
      check("unmapped read resp", {30'h0, resp}, {30'h0, `TFP_RESP_SLVERR});
      wr(8'h30, 32'h1);
      check("unmapped write resp", {30'h0, resp}, {30'h0, `TFP_RESP_SLVERR});
      wr(`TFP_OFS_CAPTURE, 32'h1234);
      check("mapped write resp", {30'h0, resp}, {30'h0, `TFP_RESP_OKAY});
      // Counter stopped, so only the preset and the strobe can move the output state
      for (int i = 0; i < 5; i++) begin
         wr(`TFP_OFS_PORT, {26'h0, 1'b0, f_pre[i], 4'h1});
         wr(`TFP_OFS_CTRL_A, {24'h0, f_com[i], 6'h0});
         wr(`TFP_OFS_CTRL_C, 32'h80);
         tick(3);
         check("pin a enable", {31'h0, pins.enable[0]}, 32'h1);
         check("pin a level", {31'h0, pins.level[0]}, {31'h0, f_com[i] != 2'h0 && f_exp[i]});
         rd(`TFP_OFS_PORT);
         check("state a", {31'h0, rdv[4]}, {31'h0, f_exp[i]});
      end
      rd(`TFP_OFS_CAPTURE);
      check("capture", rdv, 32'h1234);
      wr(`TFP_OFS_CTRL_B, 32'h09);
      for (int i = 0; i < 6; i++) begin
         wr(`TFP_OFS_CMP_A, p_cmp[i]);
         wr(`TFP_OFS_CTRL_A, {24'h0, p_com[i], 6'h01});
         tick(600);
         measure(256, 0);
         check("pwm high clocks", hi, p_hi[i]);
      end
      rd(`TFP_OFS_STATUS);
      check("overflow flag", {31'h0, rdv[`TFP_FLD_OVF]}, 32'h1);
      // Divide by 8 stretches every level by the prescale factor
      wr(`TFP_OFS_CMP_A, 32'h40);
      wr(`TFP_OFS_CTRL_A, {24'h0, 2'h3, 6'h01});
      wr(`TFP_OFS_CTRL_B, 32'h0a);
      tick(4200);
      measure(2048, 0);
      check("pwm high clocks div8", hi, 32'd520);
      rd(`TFP_OFS_CMP_A);
      check("compare a buffer", rdv, 32'h40);
      // Stop and clear the counter so the new TOP is reached from below
      wr(`TFP_OFS_CTRL_B, 32'h08);
      wr(`TFP_OFS_COUNT, 32'h0);
      wr(`TFP_OFS_CMP_A, 32'h0);
      wr(`TFP_OFS_CTRL_A, {24'h0, 2'h1, 6'h03});
      wr(`TFP_OFS_CTRL_B, 32'h19);
      tick(600);
      measure(64, 0);
      check("toggle at zero", ch, 32'd64);
      wr(`TFP_OFS_CMP_A, 32'h3);
      tick(100);
      measure(64, 0);
      check("toggle changes", ch, 32'd16);
      check("toggle duty", hi, 32'd32);
      wr(`TFP_OFS_CTRL_B, 32'h18);
      wr(`TFP_OFS_STATUS, 32'h1);
      rd(`TFP_OFS_STATUS);
      check("overflow cleared", {31'h0, rdv[`TFP_FLD_OVF]}, 32'h0);
      // Unit B in CTC with the capture register as TOP, real matches
      wr(`TFP_OFS_CTRL_A, 32'h50);
      wr(`TFP_OFS_CAPTURE, 32'h7);
      wr(`TFP_OFS_PORT, 32'h02);
      wr(`TFP_OFS_CTRL_C, 32'h40);
      tick(3);
      check("pin b enable", {30'h0, pins.enable}, 32'h2);
      check("pin b forced", {31'h0, pins.level[1]}, 32'h1);
      wr(`TFP_OFS_COUNT, 32'h0);
      wr(`TFP_OFS_CMP_B, 32'h3);
      wr(`TFP_OFS_CTRL_B, 32'h19);
      tick(20);
      measure(64, 1);
      check("ctc toggle b", ch, 32'd8);
      check("ctc duty b", hi, 32'd32);
      wr(`TFP_OFS_CTRL_A, 32'h20);
      tick(20);
      check("ctc clear b", {31'h0, pins.level[1]}, 32'h0);
      wr(`TFP_OFS_CTRL_A, 32'h30);
      tick(20);
      check("ctc set b", {31'h0, pins.level[1]}, 32'h1);
      wr(`TFP_OFS_CTRL_A, 32'h00);
      tick(20);
      rd(`TFP_OFS_PORT);
      check("mode zero keeps b", {31'h0, rdv[5]}, 32'h1);
      check("pin b port value", {31'h0, pins.level[1]}, 32'h0);
      stop_test();
   end

   // Whole run needs about 13000 clocks
   initial begin
      #160000;
      n_fail++;
      stop_test();
   end
endmodule : test_timer_fast_pwm_compare_output
